// ---- src/tft_timing_gen.v ----
// TFT panel timing generator with Wishbone register slave
// Summary of operation
// - When enabled the pixel clock runs continuously and the panel samples on its falling edge.
// - Line sync starts each line and lasts at least one pixel clock.
// - Frame sync starts each frame and lasts at least one whole line.
// - Data enable qualifies pixel data; when low the data is invalid.
// - Line and frame sync polarity are chosen separately, active high after reset.
// - Data enable is always active high.
// - The pixel clock can be inverted and delayed via the clock divider setting.
// - Data, syncs and enable change on the rising pixel clock edge when the clock is neither inverted nor delayed.
// - A frame lasts sync, back porch, front porch and active lines, in whole lines.
// - Active size, horizontal and vertical timings sit in separate settings.
// - The pixel clock period is never shorter than the minimum.
`timescale 1ns/1ps
`default_nettype none
`include "tft_regs.vh"
module tft_timing_gen (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [23:0] pixel_i,
  output reg         pixel_req_o,
  output wire        pclk_o,
  output reg         hsync_o,
  output reg         vsync_o,
  output reg         data_enable_out_o,
  output reg  [23:0] line_pixel_data_o
);
  localparam S_SYNC  = 4'b0001;
  localparam S_BACK  = 4'b0010;
  localparam S_ACT   = 4'b0100;
  localparam S_FRONT = 4'b1000;

  reg  [31:0] ctrl_reg;
  reg  [31:0] display_size_setting_reg;
  reg  [31:0] horizontal_timing_setting_reg;
  reg  [31:0] vertical_timing_setting_reg;
  reg  [31:0] sync_polarity_setting_reg;
  reg  [31:0] clkdiv_reg;
  reg  [3:0]  hst_reg;
  reg  [3:0]  vst_reg;
  reg  [11:0] hcnt_reg;
  reg  [11:0] vcnt_reg;
  reg  [15:0] frame_cnt_reg;
  reg  [3:0]  hst_next;
  reg  [3:0]  vst_next;
  reg  [11:0] hcnt_next;
  reg  [11:0] vcnt_next;
  reg         line_end;
  reg  [31:0] rd_data;
  wire        tick;
  wire        run;
  wire [3:0]  idx;
  wire [11:0] hsync_width;
  wire [11:0] h_back_porch;
  wire [11:0] h_front_porch;
  wire [11:0] v_active;
  wire [11:0] h_active;
  wire [11:0] vsync_width;
  wire [11:0] v_back_porch;
  wire [11:0] v_front_porch;

  // ====================================================
  // Field decode
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer i;
    begin
      for (i = 0; i < 32; i = i + 1) begin
        merge[i] = sel[i / 8] ? dat[i] : old[i];
      end
    end
  endfunction

  function [11:0] atleast1;
    input [11:0] v;
    begin
      atleast1 = (v == 12'h000) ? 12'h001 : v;
    end
  endfunction

  assign run           = ctrl_reg[`TFT_CTRL_EN_BIT];
  assign idx           = wb_adr_i[5:2];
  assign h_active      = atleast1(display_size_setting_reg[11:0]);
  assign v_active      = atleast1(display_size_setting_reg[27:16]);
  assign hsync_width   = atleast1({4'h0, horizontal_timing_setting_reg[7:0]});
  assign h_back_porch  = atleast1({4'h0, horizontal_timing_setting_reg[15:8]});
  assign h_front_porch = atleast1({4'h0, horizontal_timing_setting_reg[23:16]});
  assign vsync_width   = atleast1({4'h0, vertical_timing_setting_reg[7:0]});
  assign v_back_porch  = atleast1({4'h0, vertical_timing_setting_reg[15:8]});
  assign v_front_porch = atleast1({4'h0, vertical_timing_setting_reg[23:16]});

  // ====================================================
  // Wishbone slave
  always @* begin
    case (idx)
      `TFT_ADR_CTRL:      rd_data = ctrl_reg;
      `TFT_ADR_DISPLAY_SIZE_SETTING: rd_data = display_size_setting_reg;
      `TFT_ADR_HTIMING:   rd_data = horizontal_timing_setting_reg;
      `TFT_ADR_VTIMING:   rd_data = vertical_timing_setting_reg;
      `TFT_ADR_POLARITY:  rd_data = sync_polarity_setting_reg;
      `TFT_ADR_CLKDIV:    rd_data = clkdiv_reg;
      `TFT_ADR_STATUS:    rd_data = {frame_cnt_reg, vst_reg, vcnt_reg};
      default:            rd_data = 32'h00000000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o                      <= 1'b0;
      wb_dat_o                      <= 32'h00000000;
      ctrl_reg                      <= `TFT_RST_CTRL;
      display_size_setting_reg      <= `TFT_RST_DISPLAY_SIZE_SETTING;
      horizontal_timing_setting_reg <= `TFT_RST_HTIMING;
      vertical_timing_setting_reg   <= `TFT_RST_VTIMING;
      sync_polarity_setting_reg     <= `TFT_RST_POLARITY;
      clkdiv_reg                    <= `TFT_RST_CLKDIV;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : rd_data;
        if (wb_we_i) begin
          case (idx)
            `TFT_ADR_CTRL:      ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h00000001;
            `TFT_ADR_DISPLAY_SIZE_SETTING: display_size_setting_reg <=
                                  merge(display_size_setting_reg, wb_dat_i, wb_sel_i) & 32'h0FFF0FFF;
            `TFT_ADR_HTIMING:   horizontal_timing_setting_reg <=
                                  merge(horizontal_timing_setting_reg, wb_dat_i, wb_sel_i) & 32'h00FFFFFF;
            `TFT_ADR_VTIMING:   vertical_timing_setting_reg <=
                                  merge(vertical_timing_setting_reg, wb_dat_i, wb_sel_i) & 32'h00FFFFFF;
            `TFT_ADR_POLARITY:  sync_polarity_setting_reg <=
                                  merge(sync_polarity_setting_reg, wb_dat_i, wb_sel_i) & 32'h00000003;
            `TFT_ADR_CLKDIV:    clkdiv_reg <=
                                  merge(clkdiv_reg, wb_dat_i, wb_sel_i) & 32'h000F01FF;
            default: ;
          endcase
        end
      end
    end
  end

  // ====================================================
  // Pixel clock
  tft_pclk_gen u_pclk (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .div_i  (clkdiv_reg[`TFT_CLKDIV_DIV_MSB:`TFT_CLKDIV_DIV_LSB]),
    .inv_i  (clkdiv_reg[`TFT_CLKDIV_INV_BIT]),
    .dly_i  (clkdiv_reg[`TFT_CLKDIV_DLY_MSB:`TFT_CLKDIV_DLY_LSB]),
    .tick_o (tick),
    .pclk_o (pclk_o)
  );

  // ====================================================
  // Horizontal sequencer
  always @* begin
    hst_next  = hst_reg;
    hcnt_next = hcnt_reg + 12'h001;
    line_end  = 1'b0;
    case (hst_reg)
      S_SYNC:  if (hcnt_reg + 12'h001 >= hsync_width) begin hst_next = S_BACK; hcnt_next = 12'h000; end
      S_BACK:  if (hcnt_reg + 12'h001 >= h_back_porch) begin hst_next = S_ACT; hcnt_next = 12'h000; end
      S_ACT:   if (hcnt_reg + 12'h001 >= h_active) begin hst_next = S_FRONT; hcnt_next = 12'h000; end
      S_FRONT: if (hcnt_reg + 12'h001 >= h_front_porch) begin
        hst_next  = S_SYNC;
        hcnt_next = 12'h000;
        line_end  = 1'b1;
      end
      default: begin hst_next = S_SYNC; hcnt_next = 12'h000; end
    endcase
  end

  // ====================================================
  // Vertical sequencer
  always @* begin
    vst_next  = vst_reg;
    vcnt_next = vcnt_reg;
    if (line_end) begin
      vcnt_next = vcnt_reg + 12'h001;
      case (vst_reg)
        S_SYNC:  if (vcnt_reg + 12'h001 >= vsync_width) begin vst_next = S_BACK; vcnt_next = 12'h000; end
        S_BACK:  if (vcnt_reg + 12'h001 >= v_back_porch) begin vst_next = S_ACT; vcnt_next = 12'h000; end
        S_ACT:   if (vcnt_reg + 12'h001 >= v_active) begin vst_next = S_FRONT; vcnt_next = 12'h000; end
        S_FRONT: if (vcnt_reg + 12'h001 >= v_front_porch) begin vst_next = S_SYNC; vcnt_next = 12'h000; end
        default: begin vst_next = S_SYNC; vcnt_next = 12'h000; end
      endcase
    end
  end

  // ====================================================
  // Counters and panel outputs
  always @(posedge clk_i) begin
    if (rst_i || !run) begin
      hst_reg           <= S_SYNC;
      vst_reg           <= S_SYNC;
      hcnt_reg          <= 12'h000;
      vcnt_reg          <= 12'h000;
      hsync_o           <= 1'b0;
      vsync_o           <= 1'b0;
      data_enable_out_o <= 1'b0;
      line_pixel_data_o <= 24'h000000;
      pixel_req_o       <= 1'b0;
      if (rst_i) begin
        frame_cnt_reg <= 16'h0000;
      end
    end else begin
      pixel_req_o <= 1'b0;
      if (tick) begin
        hst_reg  <= hst_next;
        hcnt_reg <= hcnt_next;
        vst_reg  <= vst_next;
        vcnt_reg <= vcnt_next;
        if (line_end && vst_reg == S_FRONT && vst_next == S_SYNC) begin
          frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
        hsync_o <= (hst_reg == S_SYNC) ^ sync_polarity_setting_reg[`TFT_POL_HS_BIT];
        vsync_o <= (vst_reg == S_SYNC) ^ sync_polarity_setting_reg[`TFT_POL_VS_BIT];
        data_enable_out_o <= (hst_reg == S_ACT) && (vst_reg == S_ACT);
        pixel_req_o <= (hst_reg == S_ACT) && (vst_reg == S_ACT);
        line_pixel_data_o <= ((hst_reg == S_ACT) && (vst_reg == S_ACT)) ? pixel_i : 24'h000000;
      end
    end
  end
endmodule // tft_timing_gen
`default_nettype wire

// ---- src/tft_regs.vh ----
// Register offsets, fields, reset values and timing counts of the TFT timing generator
`ifndef TFT_REGS_VH
`define TFT_REGS_VH
`define TFT_ADR_CTRL        4'h0
`define TFT_ADR_DISPLAY_SIZE_SETTING   4'h1
`define TFT_ADR_HTIMING     4'h2
`define TFT_ADR_VTIMING     4'h3
`define TFT_ADR_POLARITY    4'h4
`define TFT_ADR_CLKDIV      4'h5
`define TFT_ADR_STATUS      4'h6
`define TFT_CTRL_EN_BIT     0
`define TFT_POL_HS_BIT      0
`define TFT_POL_VS_BIT      1
`define TFT_CLKDIV_DIV_LSB  0
`define TFT_CLKDIV_DIV_MSB  7
`define TFT_CLKDIV_INV_BIT  8
`define TFT_CLKDIV_DLY_LSB  16
`define TFT_CLKDIV_DLY_MSB  19
`define TFT_RST_CTRL        32'h00000000
`define TFT_RST_DISPLAY_SIZE_SETTING   32'h01E00280
`define TFT_RST_HTIMING     32'h00601030
`define TFT_RST_VTIMING     32'h0002210A
`define TFT_RST_POLARITY    32'h00000000
`define TFT_RST_CLKDIV      32'h00000001
`define TFT_PCLK_MIN_PS     6660
`define TFT_CLK_PERIOD_PS   20000
`define TFT_PCLK_MIN_CYC    ((`TFT_PCLK_MIN_PS + `TFT_CLK_PERIOD_PS - 1) / `TFT_CLK_PERIOD_PS)
`endif

// ---- src/tft_pclk_gen.v ----
// Pixel clock divider with inversion and programmable delay
`timescale 1ns/1ps
`default_nettype none
`include "tft_regs.vh"
module tft_pclk_gen (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        run_i,
  input  wire [7:0]  div_i,
  input  wire        inv_i,
  input  wire [3:0]  dly_i,
  output reg         tick_o,
  output reg         pclk_o
);
  reg  [7:0]  cnt_reg;
  reg         ph_reg;
  reg  [15:0] dl_reg;
  wire [7:0]  half;
  wire [31:0] min_cyc;
  wire        raw;
  // ====================================================
  // Divider
  assign min_cyc = `TFT_PCLK_MIN_CYC;
  assign half    = (div_i < min_cyc[7:0]) ? min_cyc[7:0] : div_i;
  always @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_reg <= 8'h00;
      ph_reg  <= 1'b0;
      tick_o  <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (cnt_reg + 8'h01 >= half) begin
        cnt_reg <= 8'h00;
        ph_reg  <= ~ph_reg;
        tick_o  <= ~ph_reg;
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
  // ====================================================
  // Delay line and inversion
  always @(posedge clk_i) begin
    if (rst_i) begin
      dl_reg <= 16'h0000;
      pclk_o <= 1'b0;
    end else begin
      dl_reg <= {dl_reg[14:0], ph_reg};
      pclk_o <= inv_i ^ raw;
    end
  end
  assign raw = (dly_i == 4'h0) ? ph_reg : dl_reg[dly_i - 4'h1];
endmodule // tft_pclk_gen
`default_nettype wire

// ---- dv/tft_timing_gen_asserts.sv ----
// Port checker for the TFT timing generator
`timescale 1ns/1ps
`default_nettype none
module tft_timing_gen_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        pixel_req_o,
  input wire logic        hsync_o,
  input wire logic        vsync_o,
  input wire logic        data_enable_out_o,
  input wire logic [23:0] line_pixel_data_o
);
  logic [1:0] pol_reg;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========
  // Sync polarity shadow
  always @(posedge clk_i) begin
    if (rst_i)
      pol_reg <= 2'h0;
    else if (wb_ack_o && wb_we_i && wb_adr_i[5:2] == 4'h4 && wb_sel_i[0])
      pol_reg <= wb_dat_i[1:0];
  end
  // ==========
  // Properties
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_idle;
    !(wb_cyc_i && wb_stb_i);
  endsequence
  property p_ack_resp; s_take |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("long ack");
  property p_ack_only; s_idle |=> !wb_ack_o; endproperty
  a_ack_only: assert property (p_ack_only) else $error("stray ack");
  property p_rst_out; $past(rst_i) |-> !hsync_o && !vsync_o && !data_enable_out_o; endproperty
  a_rst_out: assert property (p_rst_out) else $error("sync active after reset");
  property p_hs_hold; $changed(hsync_o) |=> $stable(hsync_o); endproperty
  a_hs_hold: assert property (p_hs_hold) else $error("short line sync");
  property p_vs_hold; $changed(vsync_o) |=> $stable(vsync_o)[*2]; endproperty
  a_vs_hold: assert property (p_vs_hold) else $error("short frame sync");
  property p_de_data; !data_enable_out_o |-> line_pixel_data_o == 24'h0; endproperty
  a_de_data: assert property (p_de_data) else $error("data outside enable");
  property p_de_quiet; data_enable_out_o |-> hsync_o == pol_reg[0] && vsync_o == pol_reg[1]; endproperty
  a_de_quiet: assert property (p_de_quiet) else $error("enable during sync");
  property p_req_pulse; pixel_req_o |=> !pixel_req_o; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("long pixel request");
endmodule  // tft_timing_gen_asserts
bind tft_timing_gen tft_timing_gen_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .pixel_req_o(pixel_req_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
  .data_enable_out_o(data_enable_out_o), .line_pixel_data_o(line_pixel_data_o));
`default_nettype wire

// ---- dv/tft_panel_model.sv ----
// Behavioural model of the TFT panel
`timescale 1ns/1ps
`default_nettype none
module tft_panel_model (
  input wire logic        pclk_i,
  input wire logic        hsync_i,
  input wire logic        vsync_i,
  input wire logic        de_i,
  input wire logic [23:0] data_i,
  input wire logic [1:0]  pol_i,
  output logic [11:0]     px_line_o,
  output logic [11:0]     lines_o,
  output logic [11:0]     act_lines_o,
  output logic [23:0]     pix_o
);
  logic [11:0] px = 12'h0;
  logic [11:0] ln = 12'h0;
  logic [11:0] al = 12'h0;
  logic        hs_d = 1'b0;
  logic        vs_d = 1'b0;
  wire logic   hs_act = hsync_i ^ pol_i[0];
  wire logic   vs_act = vsync_i ^ pol_i[1];
  // ==========
  // Capture half a pixel period after launch, once outputs have settled, when the clock is neither inverted nor delayed
  always @(negedge pclk_i) begin
    hs_d <= hs_act;
    vs_d <= vs_act;
    if (de_i) begin
      px <= px + 12'h1;
      pix_o <= data_i;
    end
    if (hs_act && !hs_d) begin
      px <= 12'h0;
      ln <= ln + 12'h1;
      if (px != 12'h0) begin
        px_line_o <= px;
        al <= al + 12'h1;
      end
    end
    if (vs_act && !vs_d) begin
      lines_o <= ln;
      act_lines_o <= al;
      ln <= 12'h1;
      al <= 12'h0;
    end
  end
endmodule  // tft_panel_model
`default_nettype wire

// ---- dv/test_tft_timing_gen.sv ----
// Testbench for the TFT timing generator
`timescale 1ns/1ps
`default_nettype none
`include "tft_regs.vh"
module test_tft_timing_gen;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [23:0] pix = 24'h0;
  logic [1:0]  pol = 2'h0;
  logic [31:0] q;
  logic [31:0] rv [6] = '{`TFT_RST_CTRL, `TFT_RST_DISPLAY_SIZE_SETTING, `TFT_RST_HTIMING, `TFT_RST_VTIMING,
                         `TFT_RST_POLARITY, `TFT_RST_CLKDIV};
  wire logic [31:0] dat_o;
  wire logic        ack, req, pclk, hs, vs, de;
  wire logic [23:0] ld, m_pix;
  wire logic [11:0] m_px, m_ln, m_al;
  int fails = 0;
  int comparisons = 0;
  int c;
  always #10 clk_i = ~clk_i;
  tft_timing_gen dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pixel_i(pix),
    .pixel_req_o(req), .pclk_o(pclk), .hsync_o(hs), .vsync_o(vs), .data_enable_out_o(de),
    .line_pixel_data_o(ld));
  tft_panel_model panel_u (.pclk_i(pclk), .hsync_i(hs), .vsync_i(vs), .de_i(de), .data_i(ld),
    .pol_i(pol), .px_line_o(m_px), .lines_o(m_ln), .act_lines_o(m_al), .pix_o(m_pix));
  // ==========
  // Tasks
  task give_verdict;
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= {26'h0, a, 2'h0};
    dat <= d;
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      cmp(32'h0, 32'h1);
      give_verdict;
    end
  endtask
  function automatic logic act(input int s);
    if (s == 0)
      return hs ^ pol[0];
    if (s == 1)
      return vs ^ pol[1];
    return pclk;
  endfunction
  task automatic per(input int s);
    int n;
    int k;
    logic p;
    logic r;
    k = 0;
    c = 0;
    p = act(s);
    for (n = 0; n < 3000 && k < 2; n++) begin
      @(posedge clk_i);
      r = act(s);
      if (k == 1)
        c++;
      if (r && !p)
        k++;
      p = r;
    end
    if (k < 2) begin
      cmp(32'h0, 32'h1);
      give_verdict;
    end
  endtask
  task run_check;
    wb(4'h0, 1'b1, 4'hF, 32'h1);
    per(0);
    cmp(32'(c), 32'h10);
    per(2);
    cmp(32'(c), 32'h2);
    per(1);
    cmp(32'(c), 32'h50);
    repeat (4) @(posedge clk_i);
    cmp({20'h0, m_ln}, 32'h5);
    cmp({20'h0, m_al}, 32'h2);
    cmp({20'h0, m_px}, 32'h4);
    cmp({8'h0, m_pix}, {8'h0, pix});
    repeat (2) @(posedge clk_i);
    wb(4'h0, 1'b1, 4'hF, 32'h0);
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(i[3:0], 1'b0, 4'hF, 32'h0);
      cmp(q, rv[i]);
    end
    wb(4'h7, 1'b1, 4'hF, 32'hFFFFFFFF);
    wb(4'h7, 1'b0, 4'hF, 32'h0);
    cmp(q, 32'h0);
    wb(4'h1, 1'b1, 4'hF, 32'h00020004);
    wb(4'h2, 1'b1, 4'hF, 32'h00010199);
    wb(4'h2, 1'b1, 4'h1, 32'hFFFFFF02);
    wb(4'h2, 1'b0, 4'hF, 32'h0);
    cmp(q, 32'h00010102);
    wb(4'h3, 1'b1, 4'hF, 32'h00010101);
    pix <= 24'hA5C3E1;
    run_check;
    pol <= 2'h3;
    pix <= 24'h123456;
    wb(4'h4, 1'b1, 4'hF, 32'h3);
    run_check;
    pol <= 2'h0;
    wb(4'h4, 1'b1, 4'hF, 32'h0);
    wb(4'h5, 1'b1, 4'hF, 32'h00030102);
    wb(4'h0, 1'b1, 4'hF, 32'h1);
    per(2);
    cmp(32'(c), 32'h4);
    per(1);
    cmp(32'(c), 32'hA0);
    give_verdict;
  end
endmodule  // test_tft_timing_gen
`default_nettype wire
